// [logic/sfps_pkg.sv]
// shared constants and types for the serial flash protocol front end
package sfps_pkg;

  // apb register map (byte addresses)
  localparam logic [7:0] APB_STATE = 8'h00;
  localparam logic [7:0] APB_CTRL = 8'h04;
  localparam logic [7:0] APB_REGS = 8'h08;

  // apb field positions
  localparam int CTRL_BUSY_BIT = 0;
  localparam int CTRL_RESCUE_BIT = 1;

  // reset values of the host registers
  localparam logic [15:0] NVCR_RST = 16'hFFFF;
  localparam logic [7:0] VCR_RST = 8'hFF;
  localparam logic [7:0] EVCR_RST = 8'hFF;
  localparam logic [5:0] SR_HI_RST = 6'h00;
  localparam logic [1:0] LOCK_RST = 2'h0;

  // field positions
  localparam int SR_SRWD_BIT = 7;
  localparam int NV_DUAL_BIT = 2;
  localparam int NV_QUAD_BIT = 3;
  localparam int EV_DUAL_BIT = 6;
  localparam int EV_QUAD_BIT = 7;
  localparam int LK_DOWN_BIT = 1;

  // serial frame states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_OPC = 5'h02,
    ST_WDAT = 5'h04,
    ST_RDAT = 5'h08,
    ST_SKIP = 5'h10
  } sfps_state_e;

  // transfer protocol: extended, dual, quad
  typedef enum logic [1:0] {
    PR_EXT = 2'h0,
    PR_DUAL = 2'h1,
    PR_QUAD = 2'h2
  } sfps_proto_e;

  // quad wins when both selector bits are active (low)
  function automatic sfps_proto_e proto_from(input logic quad_n,
                                             input logic dual_n);
    if (!quad_n) begin
      return PR_QUAD;
    end else if (!dual_n) begin
      return PR_DUAL;
    end
    return PR_EXT;
  endfunction : proto_from

endpackage : sfps_pkg

// [logic/sfps_sync.sv]
// two-flop synchroniser bank for pin inputs
module sfps_sync #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge clock) begin
    if (srst) begin
      meta <= RST_VAL;
      dout <= RST_VAL;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule : sfps_sync

// [logic/sfps_front.sv]
// serial flash front end: spi modes, protocol select, config registers
//
// What this block does
// - sample inputs on serial clock rise, present outputs from its fall.
// - work with clock idling low or high; only idle level differs.
// - both idle modes apply to extended, dual and quad alike.
// - only a selected device drives its output; others stay high-z.
// - extended is default; opcode on line zero only.
// - enhanced write with bit6=0, bit7=1 switches to dual at once.
// - enhanced write with bit7=0 switches to quad at once.
// - volatile choice reverts on power-on, rescue or new enhanced write.
// - nonvolatile bit2 active with bit3 at 1 makes every later boot start in dual.
// - nonvolatile bit3 at 0 makes every later boot start in quad.
// - quad falls back to extended while busy with high voltage.
// - every boot loads working protocol from nonvolatile register, working vcr from its reset value.
// - volatile or enhanced writes copy into working config at once.
// - working config is never directly read or written by the host.
// - host reaches status, nv, volatile, enhanced, flag, lock regs.
// - writing commands run only on a whole multiple of eight bits shifted in.
// - modifying commands need the write enable latch set first.
//
// Chosen here: the APB register port and the register offsets.
module sfps_front
  import sfps_pkg::*;
#(
  parameter logic [7:0] OP_WREN = 8'h06,
  parameter logic [7:0] OP_RDSR = 8'h05,
  parameter logic [7:0] OP_WRSR = 8'h01,
  parameter logic [7:0] OP_RDFSR = 8'h70,
  parameter logic [7:0] OP_RDVCR = 8'h85,
  parameter logic [7:0] OP_WRVCR = 8'h81,
  parameter logic [7:0] OP_RDEVCR = 8'h65,
  parameter logic [7:0] OP_WREVCR = 8'h61,
  parameter logic [7:0] OP_RDNVCR = 8'hB5,
  parameter logic [7:0] OP_WRNVCR = 8'hB1,
  parameter logic [7:0] OP_RDLR = 8'hE8,
  parameter logic [7:0] OP_WRLR = 8'hE5
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic boot_load,
  input wire logic sclk_pin,
  input wire logic sel_n_pin,
  input wire logic vpp_pin,
  input wire logic wp_n_pin,
  input wire logic [3:0] serial_line_in,
  output logic [3:0] serial_line_out,
  output logic [3:0] serial_line_oe,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  // pin synchronisers
  logic [7:0] sync_out;
  logic sclk_s;
  logic sel_n_s;
  logic vpp_s;
  logic wp_n_s;
  logic [3:0] line_s;

  sfps_sync #(
    .WIDTH(8),
    .RST_VAL(8'h0A)
  ) u_sync (
    .clock(clock),
    .srst(srst),
    .din({serial_line_in, wp_n_pin, vpp_pin, sel_n_pin, sclk_pin}),
    .dout(sync_out)
  );

  assign sclk_s = sync_out[0];
  assign sel_n_s = sync_out[1];
  assign vpp_s = sync_out[2];
  assign wp_n_s = sync_out[3];
  assign line_s = sync_out[7:4];

  // frame state
  sfps_state_e state;
  logic sclk_d;
  logic sel_d;
  logic [7:0] shreg;
  logic [3:0] bitcnt;
  logic [2:0] pulses;
  logic [7:0] opcode;
  logic [1:0] nbytes;
  logic [7:0] byte0;
  logic [7:0] byte1;
  logic [7:0] out_shift;
  logic [3:0] out_cnt;
  logic out_idx;

  // host registers and working configuration
  logic [5:0] sr_hi;
  logic wel;
  logic [15:0] nvcr;
  logic [7:0] vcr;
  logic [7:0] evcr;
  logic [1:0] lock;
  sfps_proto_e work_proto;
  logic [7:0] work_vcr;
  logic ctrl_busy;
  logic rescue;

  // edge detection on the synchronised serial clock
  logic rise;
  logic fall;
  // polarity free
  // only edges count, so idle level of either mode never acts
  assign rise = sclk_s & ~sclk_d;
  assign fall = ~sclk_s & sclk_d;

  // protocol in force
  sfps_proto_e eff_proto;
  assign eff_proto = (work_proto == PR_QUAD && vpp_s && ctrl_busy) ?
                     PR_EXT : work_proto;

  logic [3:0] lanes;
  assign lanes = (eff_proto == PR_QUAD) ? 4'h4 :
                 (eff_proto == PR_DUAL) ? 4'h2 : 4'h1;

  logic [7:0] next_sh;
  assign next_sh = (eff_proto == PR_QUAD) ? {shreg[3:0], line_s} :
                   (eff_proto == PR_DUAL) ? {shreg[5:0], line_s[1:0]} :
                   {shreg[6:0], line_s[0]};

  logic [3:0] next_cnt;
  logic byte_done;
  assign next_cnt = bitcnt + lanes;
  assign byte_done = next_cnt[3];

  logic [3:0] next_out_cnt;
  assign next_out_cnt = out_cnt + lanes;

  logic [3:0] drive_bits;
  logic [3:0] drive_oe;
  assign drive_bits = (eff_proto == PR_QUAD) ? out_shift[7:4] :
                      (eff_proto == PR_DUAL) ? {2'h0, out_shift[7:6]} :
                      {2'h0, out_shift[7], 1'b0};
  assign drive_oe = (eff_proto == PR_QUAD) ? 4'hF :
                    (eff_proto == PR_DUAL) ? 4'h3 : 4'h2;

  // byte views of the host registers
  logic [7:0] status_byte;
  logic [7:0] flag_byte;
  assign status_byte = {sr_hi, wel, ctrl_busy};
  assign flag_byte = {~ctrl_busy, 7'h00};

  function automatic logic [7:0] rd_pick(input logic [7:0] op,
                                         input logic idx);
    logic [7:0] r;
    r = 8'h00;
    if (op == OP_RDSR) begin
      r = status_byte;
    end else if (op == OP_RDFSR) begin
      r = flag_byte;
    end else if (op == OP_RDVCR) begin
      r = vcr;
    end else if (op == OP_RDEVCR) begin
      r = evcr;
    end else if (op == OP_RDNVCR) begin
      r = idx ? nvcr[15:8] : nvcr[7:0];
    end else if (op == OP_RDLR) begin
      r = {6'h00, lock};
    end
    return r;
  endfunction : rd_pick

  function automatic logic is_wr(input logic [7:0] op);
    return op == OP_WRSR || op == OP_WRVCR || op == OP_WREVCR ||
           op == OP_WRNVCR || op == OP_WRLR;
  endfunction : is_wr

  function automatic logic is_rd(input logic [7:0] op);
    return op == OP_RDSR || op == OP_RDFSR || op == OP_RDVCR ||
           op == OP_RDEVCR || op == OP_RDNVCR || op == OP_RDLR;
  endfunction : is_rd

  logic opc_phase;
  assign opc_phase = (state == ST_IDLE) || (state == ST_OPC);

  sfps_state_e next_after_opc;
  assign next_after_opc = is_wr(next_sh) ? ST_WDAT :
                          is_rd(next_sh) ? ST_RDAT : ST_SKIP;

  // serial frame engine
  always_ff @(posedge clock) begin
    if (srst) begin
      sclk_d <= 1'b0;
      sel_d <= 1'b1;
    end else begin
      sclk_d <= sclk_s;
      sel_d <= sel_n_s;
    end
  end

  always_ff @(posedge clock) begin
    if (srst || sel_n_s) begin
      state <= ST_IDLE;
      shreg <= 8'h00;
      bitcnt <= 4'h0;
      pulses <= 3'h0;
      nbytes <= 2'h0;
      out_cnt <= 4'h0;
      out_idx <= 1'b0;
      serial_line_oe <= 4'h0;
      serial_line_out <= 4'h0;
    end else if (rise) begin
      // sample on rise
      // counts bits, so a whole byte in any mode lands on a multiple of 8
      pulses <= pulses + lanes[2:0];
      if (state != ST_RDAT && state != ST_SKIP) begin
        shreg <= next_sh;
        bitcnt <= byte_done ? 4'h0 : next_cnt;
      end
      if (opc_phase) begin
        state <= byte_done ? next_after_opc : ST_OPC;
      end
      if (state == ST_WDAT && byte_done && nbytes != 2'h2) begin
        nbytes <= nbytes + 2'h1;
      end
    end else if (fall && state == ST_RDAT) begin
      serial_line_out <= drive_bits;
      serial_line_oe <= drive_oe;
      out_cnt <= next_out_cnt[3] ? 4'h0 : next_out_cnt;
      if (next_out_cnt[3]) begin
        out_idx <= ~out_idx;
      end
    end
  end

  // opcode, data bytes and outgoing shifter
  always_ff @(posedge clock) begin
    if (srst) begin
      opcode <= 8'h00;
      byte0 <= 8'h00;
      byte1 <= 8'h00;
      out_shift <= 8'h00;
    end else if (!sel_n_s && rise && byte_done) begin
      if (opc_phase) begin
        opcode <= next_sh;
        out_shift <= rd_pick(next_sh, 1'b0);
      end else if (state == ST_WDAT && nbytes == 2'h0) begin
        byte0 <= next_sh;
      end else if (state == ST_WDAT && nbytes == 2'h1) begin
        byte1 <= next_sh;
      end
    end else if (!sel_n_s && fall && state == ST_RDAT) begin
      out_shift <= next_out_cnt[3] ? rd_pick(opcode, ~out_idx) :
                   out_shift << lanes;
    end
  end

  // command execution at deselect
  logic desel_evt;
  logic whole;
  logic [1:0] need;
  logic wr_go;
  logic wren_go;
  assign desel_evt = sel_n_s & ~sel_d;
  assign whole = (pulses == 3'h0);
  assign need = (opcode == OP_WRNVCR) ? 2'h2 : 2'h1;
  assign wr_go = desel_evt && state == ST_WDAT && whole && wel &&
                 !ctrl_busy && nbytes >= need;
  assign wren_go = desel_evt && state == ST_SKIP && whole &&
                   opcode == OP_WREN;

  logic sr_locked;
  assign sr_locked = sr_hi[SR_SRWD_BIT-2] && !wp_n_s;

  logic boot;
  assign boot = boot_load;

  // write enable latch
  always_ff @(posedge clock) begin
    if (srst || boot) begin
      wel <= 1'b0;
    end else if (wren_go) begin
      wel <= 1'b1;
    end else if (wr_go) begin
      wel <= 1'b0;
    end
  end

  // nonvolatile registers survive boot_load, only srst clears them
  always_ff @(posedge clock) begin
    if (srst) begin
      nvcr <= NVCR_RST;
      sr_hi <= SR_HI_RST;
    end else if (wr_go && opcode == OP_WRNVCR) begin
      nvcr <= {byte1, byte0};
    end else if (wr_go && opcode == OP_WRSR && !sr_locked) begin
      sr_hi <= byte0[7:2];
    end
  end

  // volatile registers and working configuration
  always_ff @(posedge clock) begin
    if (srst) begin
      work_proto <= proto_from(NVCR_RST[NV_QUAD_BIT],
                               NVCR_RST[NV_DUAL_BIT]);
      work_vcr <= VCR_RST;
      vcr <= VCR_RST;
      evcr <= EVCR_RST;
      lock <= LOCK_RST;
    end else if (boot) begin
      work_proto <= proto_from(nvcr[NV_QUAD_BIT], nvcr[NV_DUAL_BIT]);
      work_vcr <= VCR_RST;
      vcr <= VCR_RST;
      evcr <= {nvcr[NV_QUAD_BIT], nvcr[NV_DUAL_BIT], EVCR_RST[5:0]};
      lock <= LOCK_RST;
    end else if (rescue) begin
      work_proto <= PR_EXT;
      evcr[EV_QUAD_BIT] <= 1'b1;
      evcr[EV_DUAL_BIT] <= 1'b1;
    end else if (wr_go && opcode == OP_WREVCR) begin
      evcr <= byte0;
      work_proto <= proto_from(byte0[EV_QUAD_BIT], byte0[EV_DUAL_BIT]);
    end else if (wr_go && opcode == OP_WRVCR) begin
      vcr <= byte0;
      work_vcr <= byte0;
    end else if (wr_go && opcode == OP_WRLR && !lock[LK_DOWN_BIT]) begin
      lock <= byte0[1:0];
    end
  end

  // apb slave: one wait state, answer registered
  logic apb_acc;
  logic apb_wr;
  logic hit_state;
  logic hit_ctrl;
  logic hit_regs;
  logic [31:0] rd_word;
  assign apb_acc = psel & penable & ~pready;
  assign apb_wr = psel & penable & pready & pwrite;
  assign hit_state = (paddr == APB_STATE);
  assign hit_ctrl = (paddr == APB_CTRL);
  assign hit_regs = (paddr == APB_REGS);

  // working config hidden
  // only the protocol in force shows, never the stored copy
  assign rd_word = hit_state ? {nvcr, opcode, 3'h0, ~sel_n_s,
                                ctrl_busy, wel, eff_proto} :
                   hit_ctrl ? {31'h0, ctrl_busy} :
                   hit_regs ? {6'h00, lock, evcr, vcr, status_byte} :
                   32'h0;

  always_ff @(posedge clock) begin
    if (srst) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_acc;
      prdata <= apb_acc ? rd_word : 32'h0;
      pslverr <= apb_acc & ~(hit_state | hit_ctrl | hit_regs);
    end
  end

  // busy flag models the array controller's program/erase cycle
  always_ff @(posedge clock) begin
    if (srst) begin
      ctrl_busy <= 1'b0;
      rescue <= 1'b0;
    end else begin
      rescue <= apb_wr & hit_ctrl & pwdata[CTRL_RESCUE_BIT];
      if (apb_wr && hit_ctrl) begin
        ctrl_busy <= pwdata[CTRL_BUSY_BIT];
      end
    end
  end

  // work_vcr steers nothing yet, not even the protocol; kept for readers
  // of later dummy-cycle and output-driver logic
  logic [7:0] unused_vcr;
  assign unused_vcr = work_vcr;

endmodule : sfps_front

// [test/sfps_checker.sv]
// assertions on the ports of the protocol front end, bound to its top
module sfps_checker
  import sfps_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic sclk_pin,
  input wire logic sel_n_pin,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic [3:0] serial_line_out,
  input wire logic [3:0] serial_line_oe,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  logic mapped;
  assign mapped = paddr inside {APB_STATE, APB_CTRL, APB_REGS};

  a_float_desel: assert property (sel_n_pin [*6] |-> serial_line_oe == 4'h0)
    else $error("data lines driven while deselected");
  // a rise must not move the output; only falls launch bits
  a_out_hold: assert property ((sclk_pin && !sel_n_pin) [*4] |->
    $stable(serial_line_out)) else $error("output moved with clock high");
  a_oe_shape: assert property (serial_line_oe inside
    {4'h0, 4'h2, 4'h3, 4'hF}) else $error("illegal output lane set");
  a_oe_select: assert property ($rose(|serial_line_oe) |->
    !$past(sel_n_pin, 2)) else $error("drive began without select");
  a_ready_time: assert property ($rose(psel && penable) |=> pready)
    else $error("bus answer late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_map: assert property (pready |-> pslverr == !mapped)
    else $error("error flag wrong for address");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer cycle");
endmodule : sfps_checker

bind sfps_front sfps_checker u_chk (.*);

// [test/sfps_spi_master.sv]
// spi bus master model driving the flash front end pins
module sfps_spi_master (
  output logic sclk_pin,
  output logic sel_n_pin,
  output logic [3:0] serial_line_in,
  input wire logic [3:0] serial_line_out,
  input wire logic [3:0] serial_line_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] drv, men, last;
  // released lines show the inverse of their last value, not a hold
  assign serial_line_in = (serial_line_oe & serial_line_out) |
    (~serial_line_oe & men & drv) | (~serial_line_oe & ~men & ~last);
  initial begin
    sclk_pin = 1'b0;
    sel_n_pin = 1'b1;
    drv = 4'h0;
    men = 4'h0;
    last = 4'h0;
  end

  // launch at the fall, take read bits at the rise
  task automatic pulse(input int w, input logic [15:0] sh, input logic rd,
                       inout logic [15:0] q);
    logic [3:0] d;
    d = sh[15:12] >> (4 - w);
    sclk_pin = 1'b0;
    men = rd ? 4'h0 : 4'hF >> (4 - w);
    drv = d;
    if (!rd) last = d;
    #24;
    sclk_pin = 1'b1;
    if (rd) q = (q << w) | (w == 1 ? {3'h0, serial_line_out[1]} :
                            serial_line_out & (4'hF >> (4 - w)));
    #24;
  endtask : pulse

  // idle level set while deselected; n<0 reads -n bytes
  task automatic frame(input logic c, input int w, input logic [7:0] op,
    input int n, input logic [15:0] d, input int xp, output logic [15:0] q);
    logic [15:0] sh;
    int k;
    q = 16'h0;
    // keep every pin edge clear of the system clock edges
    #1.2;
    sclk_pin = c;
    #48;
    sel_n_pin = 1'b0;
    #24;
    sh = {op, 8'h0};
    for (k = 0; k < 8 / w; k++) begin
      pulse(w, sh, 1'b0, q);
      sh = sh << w;
    end
    sh = {d[7:0], d[15:8]};
    for (k = 0; k < (n < 0 ? -n : n) * 8 / w + xp; k++) begin
      pulse(w, sh, n < 0, q);
      sh = sh << w;
    end
    men = 4'h0;
    sclk_pin = c;
    #24;
    sel_n_pin = 1'b1;
    #200;
  endtask : frame
endmodule : sfps_spi_master

// [test/sfps_front_tb.sv]
// self-checking bench for the serial flash protocol front end
module sfps_front_tb;
  import sfps_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [7:0] ev;
    logic c;
    logic [1:0] pr;
  } sfps_row_s;
  // enhanced value, idle clock level, protocol it must select
  sfps_row_s rows [4] = '{'{8'hBF, 1'b0, 2'h1}, '{8'h7F, 1'b1, 2'h2},
    '{8'h3F, 1'b0, 2'h2}, '{8'hFF, 1'b1, 2'h0}};
  logic clock, srst, boot_load, vpp_pin, wp_n_pin, psel, penable, pwrite;
  logic pready, pslverr, sclk_pin, sel_n_pin, e, cp;
  logic [1:0] cur;
  logic [3:0] serial_line_in, serial_line_out, serial_line_oe;
  logic [7:0] paddr;
  logic [15:0] q;
  logic [31:0] pwdata, prdata, r;
  int failures, samples_checked, i;

  sfps_front DUT (.*);
  sfps_spi_master m (.*);

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic finish_test();
    if (failures == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input string nm, input logic [31:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) failures++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rc(input string nm, input logic [7:0] a,
                    input logic [31:0] mk, exp);
    apb(1'b0, a, 32'h0);
    chk(nm, r & mk, exp);
  endtask : rc

  task automatic f(input logic [7:0] op, input int n, input logic [15:0] d,
                   input int xp);
    m.frame(cp, cur == 2'h2 ? 4 : cur == 2'h1 ? 2 : 1, op, n, d, xp, q);
  endtask : f

  // write enable frame always goes first
  task automatic wf(input logic [7:0] op, input int n, input logic [15:0] d);
    f(DUT.OP_WREN, 0, 16'h0, 0);
    f(op, n, d, 0);
  endtask : wf

  task automatic boot();
    @(posedge clock);
    boot_load <= 1'b1;
    @(posedge clock);
    boot_load <= 1'b0;
    repeat (4) @(posedge clock);
  endtask : boot

  initial begin
    #300000;
    failures++;
    finish_test();
  end

  initial begin
    srst = 1'b1;
    boot_load = 1'b0;
    vpp_pin = 1'b0;
    // protect input held at a defined level
    wp_n_pin = 1'b1;
    {psel, penable, pwrite, paddr, pwdata, cur, cp} = '0;
    repeat (16) @(posedge clock);
    srst <= 1'b0;
    repeat (3) @(posedge clock);
    rc("state", APB_STATE, 32'hFFFFFFFF, 32'hFFFF0000);
    rc("regs", APB_REGS, 32'hFFFFFFFF, 32'h00FFFF00);
    for (i = 0; i < 4; i++) begin
      cp = rows[i].c;
      wf(DUT.OP_WREVCR, 1, {8'h0, rows[i].ev});
      cur = rows[i].pr;
      rc("proto", APB_STATE, 32'h7, {30'h0, rows[i].pr});
      rc("evcr", APB_REGS, 32'hFF0000, {8'h0, rows[i].ev, 16'h0});
      f(DUT.OP_RDEVCR, -1, 16'h0, 0);
      chk("evcr_rd", {24'h0, q[7:0]}, {24'h0, rows[i].ev});
    end
    cp = 1'b0;
    f(DUT.OP_WREVCR, 1, 16'h7F, 0);
    f(DUT.OP_WREN, 0, 16'h0, 1);
    rc("no_wel", APB_STATE, 32'h7, 32'h0);
    wf(DUT.OP_WRVCR, 1, 16'h5A);
    rc("vcr", APB_REGS, 32'hFF00, 32'h5A00);
    wf(DUT.OP_WREVCR, 1, 16'h7F);
    apb(1'b1, APB_CTRL, 32'h1);
    vpp_pin <= 1'b1;
    repeat (8) @(posedge clock);
    rc("vpp_ext", APB_STATE, 32'h3, 32'h0);
    f(DUT.OP_RDSR, -1, 16'h0, 0);
    chk("status", {24'h0, q[7:0]}, 32'h1);
    vpp_pin <= 1'b0;
    repeat (8) @(posedge clock);
    rc("vpp_quad", APB_STATE, 32'h3, 32'h2);
    apb(1'b1, APB_CTRL, 32'h2);
    rc("rescue", APB_STATE, 32'hB, 32'h0);
    rc("rescue_ev", APB_REGS, 32'hC00000, 32'hC00000);
    wf(DUT.OP_WRLR, 1, 16'h02);
    wf(DUT.OP_WRLR, 1, 16'h01);
    rc("lock", APB_REGS, 32'h3000000, 32'h2000000);
    f(DUT.OP_RDLR, -1, 16'h0, 0);
    chk("lock_rd", {24'h0, q[7:0]}, 32'h2);
    f(DUT.OP_RDFSR, -1, 16'h0, 0);
    chk("flag_rd", {24'h0, q[7:0]}, 32'h80);
    wf(DUT.OP_WRSR, 1, 16'h80);
    @(posedge clock);
    wp_n_pin <= 1'b0;
    wf(DUT.OP_WRSR, 1, 16'h00);
    rc("sr_lock", APB_REGS, 32'hFC, 32'h80);
    @(posedge clock);
    wp_n_pin <= 1'b1;
    wf(DUT.OP_WRNVCR, 2, 16'hFFF7);
    rc("nv_hold", APB_STATE, 32'hFFFF0003, 32'hFFF70000);
    f(DUT.OP_RDNVCR, -2, 16'h0, 0);
    chk("nv_rd", {16'h0, q}, 32'hF7FF);
    boot();
    cur = 2'h2;
    rc("nv_quad", APB_STATE, 32'h3, 32'h2);
    wf(DUT.OP_WRNVCR, 2, 16'hFFFB);
    boot();
    cur = 2'h1;
    rc("nv_dual", APB_STATE, 32'hFFFF0003, 32'hFFFB0001);
    srst <= 1'b1;
    repeat (3) @(posedge clock);
    srst <= 1'b0;
    repeat (3) @(posedge clock);
    rc("por", APB_STATE, 32'hFFFF0003, 32'hFFFF0000);
    apb(1'b1, APB_STATE, 32'h0);
    rc("ro", APB_STATE, 32'hFFFF0000, 32'hFFFF0000);
    apb(1'b0, 8'h0C, 32'h0);
    chk("unmapped", {31'h0, e}, 32'h1);
    finish_test();
  end
endmodule : sfps_front_tb
